// ### hw/ttc_core.sv
// Three timer/counters, their control registers and the two external interrupt flags
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`include "ttc_defines.svh"

module ttc_core
    import ttc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Register port
    input wire ttc_bus_t i_bus,
    output logic [7:0] o_rdata,
    // Pins and core vectoring
    input wire ttc_pins_t i_pins,
    input wire ttc_vec_t i_vector_ack,
    // Flags and serial ticks
    output ttc_flags_t o_flags,
    output ttc_serial_t o_serial
);

    // Registers
    logic [7:0] pair_ctrl_reg, pair_ctrl_next;
    logic [7:0] pair_mode_reg, pair_mode_next;
    logic [7:0] two_ctrl_reg, two_ctrl_next;
    logic [7:0] count_high_reg [2];
    logic [7:0] count_high_next [2];
    logic [7:0] count_low_reg [2];
    logic [7:0] count_low_next [2];
    logic [15:0] two_count_reg, two_count_next;
    logic [15:0] two_reload_reg, two_reload_next;
    logic [7:0] rdata_reg, rdata_next;
    ttc_serial_t serial_reg, serial_next;
    ttc_pins_t sync1_reg, sync1_next;
    ttc_pins_t sync2_reg, sync2_next;
    ttc_pins_t prev_reg, prev_next;

    // Derived per-cycle terms
    ttc_pins_t fall;
    logic [1:0] tick;
    logic [16:0] step [2];
    logic split_mode;
    logic split_ovf;
    logic zero_ovf;
    logic one_ovf;
    logic one_raw_ovf;
    logic baud_mode;
    logic two_tick;
    logic two_ovf;
    logic two_trig;

    // Advance one timer by one count; returns {overflow, high, low}
    function automatic logic [16:0] ttc_step(input logic [1:0] mode, input logic [7:0] high,
                                             input logic [7:0] low, input logic en);
        logic [16:0] r;
        r = {1'b0, high, low};
        if (en) begin
            case (mode)
                `TTC_MODE_13BIT: begin
                    // Low bits 7:5 are left alone
                    if (low[4:0] == 5'h1f) begin
                        r[15:8] = high + 8'h01;
                        r[16] = (high == 8'hff);
                    end
                    r[4:0] = low[4:0] + 5'h01;
                end
                `TTC_MODE_16BIT: begin
                    r = {1'b0, high, low} + 17'h00001;
                end
                `TTC_MODE_8BIT_RELOAD: begin
                    if (low == 8'hff) begin
                        r = {1'b1, high, high};
                    end else begin
                        r[7:0] = low + 8'h01;
                    end
                end
                default: begin
                    // Split: only the low byte counts here
                    r[16] = (low == 8'hff);
                    r[7:0] = low + 8'h01;
                end
            endcase
        end
        return r;
    endfunction : ttc_step

    // falling edges compare the two latest synchronised samples
    assign fall = prev_reg & ~sync2_reg;

    // Pin synchroniser, first stage feeds only the second
    always_comb begin
        sync1_next = i_pins;
        sync2_next = sync1_reg;
        prev_next = sync2_reg;
    end

    // Count enable and stepping of timers zero and one
    for (genvar g = 0; g < 2; g++) begin : g_pair
        logic run;
        logic gate;
        logic count_sel;
        logic [1:0] mode;
        assign run = pair_ctrl_reg[`TTC_BIT_ZERO_RUN + 2 * g];
        assign gate = pair_mode_reg[`TTC_MODE_NIBBLE * g + `TTC_MODE_GATE_BIT];
        assign count_sel = pair_mode_reg[`TTC_MODE_NIBBLE * g + `TTC_MODE_COUNT_SEL_BIT];
        assign mode = pair_mode_reg[`TTC_MODE_NIBBLE * g + `TTC_MODE_FIELD_MSB -: 2];
        // run bit, gate and pin level, count-pin fall when selected; flag bits take no part
        // timer one in its own split mode is stopped
        assign tick[g] = run & (~gate | sync2_reg.ext_irq[g])
                         & (count_sel ? fall.count[g] : 1'b1)
                         & ~((g == 1) && (mode == `TTC_MODE_SPLIT));
        // mode field selects the counting arrangement
        assign step[g] = ttc_step(mode, count_high_reg[g], count_low_reg[g], tick[g]);
    end

    // Split mode borrows timer one's run bit for timer zero's high byte
    assign split_mode = (pair_mode_reg[`TTC_MODE_FIELD_MSB -: 2] == `TTC_MODE_SPLIT);
    assign split_ovf = split_mode & pair_ctrl_reg[`TTC_BIT_ONE_RUN] & (count_high_reg[0] == 8'hff);
    assign zero_ovf = step[0][16];
    assign one_raw_ovf = step[1][16];
    // In split mode timer one only clocks the serial port
    assign one_ovf = split_mode ? split_ovf : one_raw_ovf;

    // Timer two terms
    assign baud_mode = two_ctrl_reg[`TTC_BIT_RX_CLK_SEL] | two_ctrl_reg[`TTC_BIT_TX_CLK_SEL];
    assign two_tick = two_ctrl_reg[`TTC_BIT_TWO_RUN]
                      & (two_ctrl_reg[`TTC_BIT_TWO_COUNT_SEL] ? fall.two_count : 1'b1);
    assign two_ovf = two_tick & (two_count_reg == 16'hffff);
    // trigger edges only count with the enable set
    assign two_trig = fall.two_trigger & two_ctrl_reg[`TTC_BIT_TWO_TRIG_EN];

    // Next count bytes of timers zero and one; a write beats counting
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            count_high_next[i] = step[i][15:8];
            count_low_next[i] = step[i][7:0];
        end
        if (split_mode && pair_ctrl_reg[`TTC_BIT_ONE_RUN]) begin
            count_high_next[0] = count_high_reg[0] + 8'h01;
        end
        if (i_bus.wr) begin
            if (i_bus.addr == `TTC_ADDR_TIMER_ZERO_LOW) begin
                count_low_next[0] = i_bus.wdata;
            end else if (i_bus.addr == `TTC_ADDR_TIMER_ONE_LOW) begin
                count_low_next[1] = i_bus.wdata;
            end else if (i_bus.addr == `TTC_ADDR_TIMER_ZERO_HIGH) begin
                count_high_next[0] = i_bus.wdata;
            end else if (i_bus.addr == `TTC_ADDR_TIMER_ONE_HIGH) begin
                count_high_next[1] = i_bus.wdata;
            end
        end
    end

    // Next count and reload bytes of timer two
    always_comb begin
        two_count_next = two_count_reg + {15'h0000, two_tick};
        two_reload_next = two_reload_reg;
        if (two_ovf && (baud_mode || !two_ctrl_reg[`TTC_BIT_TWO_CAPTURE])) begin
            two_count_next = two_reload_reg;
        end
        // trigger edge reloads or captures unless serial
        if (two_trig && !baud_mode) begin
            if (two_ctrl_reg[`TTC_BIT_TWO_CAPTURE]) begin
                two_reload_next = two_count_reg;
            end else begin
                two_count_next = two_reload_reg;
            end
        end
        if (i_bus.wr) begin
            if (i_bus.addr == `TTC_ADDR_TIMER_TWO_LOW) begin
                two_count_next[7:0] = i_bus.wdata;
            end else if (i_bus.addr == `TTC_ADDR_TIMER_TWO_HIGH) begin
                two_count_next[15:8] = i_bus.wdata;
            end else if (i_bus.addr == `TTC_ADDR_TWO_RELOAD_LOW) begin
                two_reload_next[7:0] = i_bus.wdata;
            end else if (i_bus.addr == `TTC_ADDR_TWO_RELOAD_HIGH) begin
                two_reload_next[15:8] = i_bus.wdata;
            end
        end
    end

    // Control registers: write, then vectoring clears, then hardware sets
    // Set comes last, so an event beats a same-cycle clear
    always_comb begin
        pair_ctrl_next = pair_ctrl_reg;
        pair_mode_next = pair_mode_reg;
        two_ctrl_next = two_ctrl_reg;
        if (i_bus.wr) begin
            if (i_bus.addr == `TTC_ADDR_PAIR_CONTROL) begin
                pair_ctrl_next = i_bus.wdata;
            end else if (i_bus.addr == `TTC_ADDR_PAIR_MODE) begin
                pair_mode_next = i_bus.wdata;
            end else if (i_bus.addr == `TTC_ADDR_TWO_CONTROL) begin
                two_ctrl_next = i_bus.wdata;
            end
        end
        // vectoring clears the pair overflow flags
        if (i_vector_ack.timer_one) begin
            pair_ctrl_next[`TTC_BIT_ONE_OVF] = 1'b0;
        end
        if (i_vector_ack.timer_zero) begin
            pair_ctrl_next[`TTC_BIT_ZERO_OVF] = 1'b0;
        end
        // vectoring clears edge-mode external flags only
        if (i_vector_ack.ext_one && pair_ctrl_reg[`TTC_BIT_EXT_ONE_EDGE]) begin
            pair_ctrl_next[`TTC_BIT_EXT_ONE_FLAG] = 1'b0;
        end
        if (i_vector_ack.ext_zero && pair_ctrl_reg[`TTC_BIT_EXT_ZERO_EDGE]) begin
            pair_ctrl_next[`TTC_BIT_EXT_ZERO_FLAG] = 1'b0;
        end
        if (one_ovf) begin
            pair_ctrl_next[`TTC_BIT_ONE_OVF] = 1'b1;
        end
        if (zero_ovf) begin
            pair_ctrl_next[`TTC_BIT_ZERO_OVF] = 1'b1;
        end
        // edge mode latches a fall, level mode follows the pin
        for (int k = 0; k < 2; k++) begin
            if (pair_ctrl_reg[`TTC_BIT_EXT_ZERO_EDGE + 2 * k]) begin
                if (fall.ext_irq[k]) begin
                    pair_ctrl_next[`TTC_BIT_EXT_ZERO_FLAG + 2 * k] = 1'b1;
                end
            end else begin
                // level flag follows the source only
                pair_ctrl_next[`TTC_BIT_EXT_ZERO_FLAG + 2 * k] = ~sync2_reg.ext_irq[k];
            end
        end
        // overflow flag suppressed while serial clocking
        if (two_ovf && !baud_mode) begin
            two_ctrl_next[`TTC_BIT_TWO_OVF] = 1'b1;
        end
        // trigger edge with enable sets the external flag
        if (two_trig) begin
            two_ctrl_next[`TTC_BIT_TWO_EXT] = 1'b1;
        end
    end

    // Serial tick selection and read data, both registered
    always_comb begin
        // timer two overflow or timer one overflow per select bit
        serial_next.rx_tick = two_ctrl_reg[`TTC_BIT_RX_CLK_SEL] ? two_ovf : one_raw_ovf;
        serial_next.tx_tick = two_ctrl_reg[`TTC_BIT_TX_CLK_SEL] ? two_ovf : one_raw_ovf;
        rdata_next = `TTC_UNMAPPED_READ;
        if (i_bus.rd) begin
            // count bytes readable at their offsets
            if (i_bus.addr == `TTC_ADDR_PAIR_CONTROL) begin
                rdata_next = pair_ctrl_reg;
            end else if (i_bus.addr == `TTC_ADDR_PAIR_MODE) begin
                rdata_next = pair_mode_reg;
            end else if (i_bus.addr == `TTC_ADDR_TIMER_ZERO_LOW) begin
                rdata_next = count_low_reg[0];
            end else if (i_bus.addr == `TTC_ADDR_TIMER_ONE_LOW) begin
                rdata_next = count_low_reg[1];
            end else if (i_bus.addr == `TTC_ADDR_TIMER_ZERO_HIGH) begin
                rdata_next = count_high_reg[0];
            end else if (i_bus.addr == `TTC_ADDR_TIMER_ONE_HIGH) begin
                rdata_next = count_high_reg[1];
            end else if (i_bus.addr == `TTC_ADDR_TWO_CONTROL) begin
                rdata_next = two_ctrl_reg;
            end else if (i_bus.addr == `TTC_ADDR_TWO_RELOAD_LOW) begin
                rdata_next = two_reload_reg[7:0];
            end else if (i_bus.addr == `TTC_ADDR_TWO_RELOAD_HIGH) begin
                rdata_next = two_reload_reg[15:8];
            end else if (i_bus.addr == `TTC_ADDR_TIMER_TWO_LOW) begin
                rdata_next = two_count_reg[7:0];
            end else if (i_bus.addr == `TTC_ADDR_TIMER_TWO_HIGH) begin
                rdata_next = two_count_reg[15:8];
            end
        end
    end

    // State registers, synchronous reset to zero, pin sample registers to ones
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            pair_ctrl_reg <= `TTC_RESET_BYTE;
            pair_mode_reg <= `TTC_RESET_BYTE;
            two_ctrl_reg <= `TTC_RESET_BYTE;
            count_high_reg[0] <= `TTC_RESET_BYTE;
            count_high_reg[1] <= `TTC_RESET_BYTE;
            count_low_reg[0] <= `TTC_RESET_BYTE;
            count_low_reg[1] <= `TTC_RESET_BYTE;
            two_count_reg <= {`TTC_RESET_BYTE, `TTC_RESET_BYTE};
            two_reload_reg <= {`TTC_RESET_BYTE, `TTC_RESET_BYTE};
            rdata_reg <= `TTC_RESET_BYTE;
            serial_reg <= '0;
            // Pins idle high, so no false edge at release
            sync1_reg <= '1;
            sync2_reg <= '1;
            prev_reg <= '1;
        end else begin
            pair_ctrl_reg <= pair_ctrl_next;
            pair_mode_reg <= pair_mode_next;
            two_ctrl_reg <= two_ctrl_next;
            count_high_reg <= count_high_next;
            count_low_reg <= count_low_next;
            two_count_reg <= two_count_next;
            two_reload_reg <= two_reload_next;
            rdata_reg <= rdata_next;
            serial_reg <= serial_next;
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            prev_reg <= prev_next;
        end
    end

    // Outputs straight from flip-flops
    assign o_rdata = rdata_reg;
    assign o_serial = serial_reg;
    assign o_flags = '{two_ext: two_ctrl_reg[`TTC_BIT_TWO_EXT],
                       two_ovf: two_ctrl_reg[`TTC_BIT_TWO_OVF],
                       timer_one: pair_ctrl_reg[`TTC_BIT_ONE_OVF],
                       timer_zero: pair_ctrl_reg[`TTC_BIT_ZERO_OVF],
                       ext_one: pair_ctrl_reg[`TTC_BIT_EXT_ONE_FLAG],
                       ext_zero: pair_ctrl_reg[`TTC_BIT_EXT_ZERO_FLAG]};

endmodule : ttc_core

// ### inc/ttc_defines.svh
// Offsets, field positions, mode codes and reset values of the timer block
`ifndef TTC_DEFINES_SVH
`define TTC_DEFINES_SVH

// Register offsets on the 8-bit register port
`define TTC_ADDR_PAIR_CONTROL      8'h88
`define TTC_ADDR_PAIR_MODE         8'h89
`define TTC_ADDR_TIMER_ZERO_LOW    8'h8a
`define TTC_ADDR_TIMER_ONE_LOW     8'h8b
`define TTC_ADDR_TIMER_ZERO_HIGH   8'h8c
`define TTC_ADDR_TIMER_ONE_HIGH    8'h8d
`define TTC_ADDR_TWO_CONTROL       8'hc8
`define TTC_ADDR_TWO_RELOAD_LOW    8'hca
`define TTC_ADDR_TWO_RELOAD_HIGH   8'hcb
`define TTC_ADDR_TIMER_TWO_LOW     8'hcc
`define TTC_ADDR_TIMER_TWO_HIGH    8'hcd

// Fields of the pair control register
`define TTC_BIT_ONE_OVF            7
`define TTC_BIT_ONE_RUN            6
`define TTC_BIT_ZERO_OVF           5
`define TTC_BIT_ZERO_RUN           4
`define TTC_BIT_EXT_ONE_FLAG       3
`define TTC_BIT_EXT_ONE_EDGE       2
`define TTC_BIT_EXT_ZERO_FLAG      1
`define TTC_BIT_EXT_ZERO_EDGE      0

// Fields of the pair mode register, per timer nibble (timer one is 4 higher)
`define TTC_MODE_NIBBLE            4
`define TTC_MODE_GATE_BIT          3
`define TTC_MODE_COUNT_SEL_BIT     2
`define TTC_MODE_FIELD_MSB         1

// Fields of the timer two control register
`define TTC_BIT_TWO_OVF            7
`define TTC_BIT_TWO_EXT            6
`define TTC_BIT_RX_CLK_SEL         5
`define TTC_BIT_TX_CLK_SEL         4
`define TTC_BIT_TWO_TRIG_EN        3
`define TTC_BIT_TWO_RUN            2
`define TTC_BIT_TWO_COUNT_SEL      1
`define TTC_BIT_TWO_CAPTURE        0

// Mode field codes of timers zero and one
`define TTC_MODE_13BIT             2'b00
`define TTC_MODE_16BIT             2'b01
`define TTC_MODE_8BIT_RELOAD       2'b10
`define TTC_MODE_SPLIT             2'b11

// Reset and unmapped read values
`define TTC_RESET_BYTE             8'h00
`define TTC_UNMAPPED_READ          8'h00

`endif

// ### inc/ttc_pkg.sv
// Types shared by the timer control block and its users
package ttc_pkg;

    // One register port request, strobes one cycle long
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ttc_bus_t;

    // Pins seen by the block, all idle high; events are falls and low levels
    typedef struct packed {
        logic two_trigger;
        logic two_count;
        logic [1:0] count;
        logic [1:0] ext_irq;
    } ttc_pins_t;

    // Vectoring acknowledges from the core, one-cycle pulses
    typedef struct packed {
        logic timer_one;
        logic timer_zero;
        logic ext_one;
        logic ext_zero;
    } ttc_vec_t;

    // Flags shown to the interrupt logic
    typedef struct packed {
        logic two_ext;
        logic two_ovf;
        logic timer_one;
        logic timer_zero;
        logic ext_one;
        logic ext_zero;
    } ttc_flags_t;

    // Baud ticks handed to the serial port
    typedef struct packed {
        logic rx_tick;
        logic tx_tick;
    } ttc_serial_t;

endpackage : ttc_pkg

// ### verification/ttc_core_asserts.sv
// Port-level checks of the timer control block, bound to its top module
`timescale 1ns/1ps
module ttc_core_asserts
    import ttc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Register port
    input wire ttc_bus_t i_bus,
    input wire logic [7:0] o_rdata,
    // Pins, vectoring and results
    input wire ttc_pins_t i_pins,
    input wire ttc_vec_t i_vector_ack,
    input wire ttc_flags_t o_flags,
    input wire ttc_serial_t o_serial
);
    logic [1:0] edge_reg;
    logic [1:0] sel_reg;
    logic trig_reg;
    logic wr_pair, wr_two;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    // Writes to the two control registers
    assign wr_pair = i_bus.wr && (i_bus.addr == 8'h88);
    assign wr_two = i_bus.wr && (i_bus.addr == 8'hc8);
    // Shadow the mode bits; hardware moves the flags
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            edge_reg <= 2'h0;
            sel_reg <= 2'h0;
            trig_reg <= 1'b0;
        end else begin
            if (wr_pair) edge_reg <= {i_bus.wdata[2], i_bus.wdata[0]};
            if (wr_two) {sel_reg, trig_reg} <= i_bus.wdata[5:3];
        end
    end
    // Read data only in the answer cycle
    rdata_idle_a: assert property (!$past(i_bus.rd) |-> o_rdata == 8'h00)
        else $error("read data outside answer cycle");
    // Edge flag set within five cycles of a pin fall
    ext_edge_a: assert property ($fell(i_pins.ext_irq[1]) ##1
        (edge_reg[1] && !i_vector_ack.ext_one && !wr_pair)[*5] |-> o_flags.ext_one)
        else $error("edge flag one not set");
    // Vectoring clears an edge flag
    ext_ack_a: assert property (i_pins.ext_irq[1] [*5] ##0
        (edge_reg[1] && i_vector_ack.ext_one && !wr_pair) |=> !o_flags.ext_one)
        else $error("edge flag one not cleared");
    // Level flag follows a low pin
    ext_level_a: assert property ((!i_pins.ext_irq[0] && !edge_reg[0] && !wr_pair)[*6]
        |-> o_flags.ext_zero)
        else $error("level flag zero not set");
    // Level flag drops with a high pin
    ext_release_a: assert property ((i_pins.ext_irq[0] && !edge_reg[0] && !wr_pair)[*6]
        |-> !o_flags.ext_zero)
        else $error("level flag zero not cleared");
    // No two overflow flag while serial clocking
    two_ovf_serial_a: assert property ($rose(o_flags.two_ovf)
        |-> $past(wr_two) || ($past(sel_reg) == 2'h0))
        else $error("two overflow set while serial clocking");
    // Timer two flags clear only by software
    two_ovf_hold_a: assert property (o_flags.two_ovf && !wr_two |=> o_flags.two_ovf)
        else $error("two overflow flag dropped");
    two_ext_hold_a: assert property (o_flags.two_ext && !wr_two |=> o_flags.two_ext)
        else $error("two external flag dropped");
    // Enabled trigger fall sets the external flag
    trig_flag_a: assert property ($fell(i_pins.two_trigger) ##1
        (trig_reg && !wr_two)[*5] |-> o_flags.two_ext)
        else $error("two external flag not set");
    // Equal clock selects give equal serial ticks
    tick_pair_a: assert property ((sel_reg[1] == sel_reg[0])[*3]
        |-> o_serial.rx_tick == o_serial.tx_tick)
        else $error("serial ticks differ");
endmodule : ttc_core_asserts

bind ttc_core ttc_core_asserts u_ttc_core_asserts (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus(i_bus), .o_rdata(o_rdata),
    .i_pins(i_pins), .i_vector_ack(i_vector_ack), .o_flags(o_flags), .o_serial(o_serial)
);

// ### verification/ttc_vector_model.sv
// Model of the core that vectors to pending timer and interrupt routines
`timescale 1ns/1ps
module ttc_vector_model
    import ttc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset_n,
    // Bench control: acknowledge, and slowly
    input wire logic i_enable,
    input wire logic i_slow,
    // Flags seen and acknowledges made
    input wire ttc_flags_t i_flags,
    output ttc_vec_t o_vec
);
    logic [3:0] pend;
    logic [1:0] wait_reg;
    // Sources the core vectors to, in acknowledge order
    assign pend = {i_flags.timer_one, i_flags.timer_zero, i_flags.ext_one, i_flags.ext_zero};
    // One-cycle pulse, then a gap so the clear is seen
    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !i_enable || o_vec != '0 || pend == 4'h0) begin
            o_vec <= '0;
            wait_reg <= 2'h0;
        end else if (i_slow && wait_reg != 2'h3) begin
            wait_reg <= wait_reg + 2'h1;
        end else begin
            o_vec <= ttc_vec_t'(pend);
        end
    end
endmodule : ttc_vector_model

// ### verification/ttc_core_bench.sv
// Self-checking bench for the timer control block
`timescale 1ns/1ps
module ttc_core_bench;
    import ttc_pkg::*;
    logic i_clk;
    logic i_reset_n;
    ttc_bus_t bus;
    ttc_pins_t pins;
    ttc_vec_t vec;
    ttc_flags_t flags;
    ttc_serial_t ser;
    logic [7:0] rdata;
    logic [7:0] obs;
    logic ack_en, ack_slow;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    ttc_core u_ttc_core (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus(bus), .o_rdata(rdata),
        .i_pins(pins), .i_vector_ack(vec), .o_flags(flags), .o_serial(ser));
    ttc_vector_model u_ttc_vector_model (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_enable(ack_en), .i_slow(ack_slow), .i_flags(flags), .o_vec(vec));
    // Ticks and flags in one vector: 7 rx, 6 tx, 5..0 flags
    assign obs = {ser, flags};
    // 50 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end
    // A few thousand cycles suffice; far beyond, it has hung
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_fail++;
            $display("FAIL cycle_limit expected below 20000 seen %0d", cycles);
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge i_clk);
        bus <= '0;
    endtask : wr
    // Read answer stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        bus <= '0;
        @(negedge i_clk);
        d = rdata;
    endtask : rd
    task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(nm, exp, d);
    endtask : rc
    task automatic wait_bit(input string nm, input int b, input logic v);
        for (int n = 0; n < 600 && obs[b] !== v; n++) @(negedge i_clk);
        chk(nm, 8'(v), 8'(obs[b]));
    endtask : wait_bit
    task automatic hold_bit(input string nm, input int b, input logic v);
        repeat (8) @(negedge i_clk);
        chk(nm, 8'(v), 8'(obs[b]));
    endtask : hold_bit
    task automatic fall_trigger();
        @(posedge i_clk);
        pins.two_trigger <= 1'b0;
        repeat (2) @(posedge i_clk);
        pins.two_trigger <= 1'b1;
    endtask : fall_trigger
    task automatic t_regs();
        logic [7:0] a [11] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'hc8, 8'hca,
            8'hcb, 8'hcc, 8'hcd};
        foreach (a[i]) rc("reset_value", a[i], 8'h00);
        wr(8'h90, 8'hff);
        rc("unmapped", 8'h90, 8'h00);
        wr(8'h8b, 8'h5a);
        rc("count_low_rw", 8'h8b, 8'h5a);
        $display("test regs done");
    endtask : t_regs
    // Rows: mode, low addr, low, high addr, high, run, flag bit, check addr, value
    task automatic t_pair();
        logic [7:0] r [4][9] = '{
            '{8'h00, 8'h8a, 8'h1e, 8'h8c, 8'hff, 8'h10, 8'h02, 8'h8c, 8'h00},
            '{8'h01, 8'h8a, 8'hfe, 8'h8c, 8'hff, 8'h10, 8'h02, 8'h8c, 8'h00},
            '{8'h20, 8'h8b, 8'hfe, 8'h8d, 8'hf0, 8'h40, 8'h03, 8'h8d, 8'hf0},
            '{8'h03, 8'h8a, 8'h00, 8'h8c, 8'hfe, 8'h40, 8'h03, 8'h8a, 8'h00}};
        foreach (r[i]) begin
            ack_slow <= i[0];
            wr(8'h89, r[i][0]);
            wr(r[i][1], r[i][2]);
            wr(r[i][3], r[i][4]);
            wr(8'h88, r[i][5]);
            wait_bit("timer_flag", r[i][6], 1'b1);
            if (r[i][0] == 8'h20) wait_bit("tx_tick", 6, 1'b1);
            wr(8'h88, (r[i][6] == 8'h02) ? 8'h20 : 8'h80);
            rc("count_byte", r[i][7], r[i][8]);
            ack_en <= 1'b1;
            wait_bit("vector_clear", r[i][6], 1'b0);
            ack_en <= 1'b0;
        end
        $display("test pair done");
    endtask : t_pair
    task automatic t_gate();
        logic [7:0] d;
        wr(8'h8a, 8'h00);
        wr(8'h8c, 8'h00);
        wr(8'h89, 8'h09);
        pins.ext_irq[0] <= 1'b0;
        repeat (4) @(posedge i_clk);
        wr(8'h88, 8'h10);
        repeat (10) @(posedge i_clk);
        rc("gated_low", 8'h8a, 8'h00);
        @(posedge i_clk);
        pins.ext_irq[0] <= 1'b1;
        repeat (10) @(posedge i_clk);
        wr(8'h88, 8'h00);
        rd(8'h8a, d);
        chk("ungated_runs", 8'h01, {7'h0, d != 8'h00});
        $display("test gate done");
    endtask : t_gate
    task automatic t_ext();
        for (int i = 0; i < 2; i++) begin
            wr(8'h88, 8'h05);
            pins.ext_irq[i] <= 1'b0;
            repeat (2) @(posedge i_clk);
            pins.ext_irq[i] <= 1'b1;
            wait_bit("edge_flag", i, 1'b1);
            hold_bit("edge_flag_held", i, 1'b1);
            ack_en <= 1'b1;
            wait_bit("edge_vector_clear", i, 1'b0);
            ack_en <= 1'b0;
            wr(8'h88, 8'h00);
            pins.ext_irq[i] <= 1'b0;
            wait_bit("level_flag", i, 1'b1);
            ack_en <= 1'b1;
            hold_bit("level_ack_kept", i, 1'b1);
            ack_en <= 1'b0;
            pins.ext_irq[i] <= 1'b1;
            wait_bit("level_follows", i, 1'b0);
        end
        $display("test ext done");
    endtask : t_ext
    task automatic t_two();
        wr(8'hca, 8'h34);
        wr(8'hcb, 8'h12);
        wr(8'hcc, 8'hfe);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h04);
        wait_bit("two_ovf", 4, 1'b1);
        wr(8'hc8, 8'h80);
        rc("reload_high", 8'hcd, 8'h12);
        hold_bit("two_ovf_held", 4, 1'b1);
        wr(8'hcd, 8'h77);
        wr(8'hc8, 8'h09);
        fall_trigger();
        wait_bit("trigger_flag", 5, 1'b1);
        rc("capture_high", 8'hcb, 8'h77);
        wr(8'hc8, 8'h01);
        fall_trigger();
        hold_bit("trigger_ignored", 5, 1'b0);
        $display("test two done");
    endtask : t_two
    task automatic t_serial();
        wr(8'hca, 8'hf0);
        wr(8'hcb, 8'hff);
        wr(8'hcc, 8'hf0);
        wr(8'hcd, 8'hff);
        wr(8'hc8, 8'h35);
        wait_bit("rx_tick", 7, 1'b1);
        wait_bit("tx_tick", 6, 1'b1);
        chk("two_ovf_serial", 8'h00, 8'(flags.two_ovf));
        wr(8'hc8, 8'h00);
        rc("serial_reload", 8'hcd, 8'hff);
        wr(8'hcc, 8'h00);
        wr(8'hcd, 8'h00);
        wr(8'h89, 8'h05);
        wr(8'h8a, 8'h00);
        wr(8'h88, 8'h10);
        wr(8'hc8, 8'h06);
        repeat (3) begin
            {pins.two_count, pins.count[0]} <= 2'b00;
            repeat (2) @(posedge i_clk);
            {pins.two_count, pins.count[0]} <= 2'b11;
            repeat (2) @(posedge i_clk);
        end
        repeat (6) @(posedge i_clk);
        wr(8'hc8, 8'h00);
        wr(8'h88, 8'h00);
        rc("pin_counts", 8'hcc, 8'h03);
        rc("pair_pin_counts", 8'h8a, 8'h03);
        $display("test serial done");
    endtask : t_serial
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    // Reset for 20 cycles, then the scenarios in turn
    initial begin
        i_reset_n = 1'b0;
        bus = '0;
        pins = '1;
        ack_en = 1'b0;
        ack_slow = 1'b0;
        repeat (20) @(posedge i_clk);
        i_reset_n <= 1'b1;
        t_regs();
        t_pair();
        t_gate();
        t_ext();
        t_two();
        t_serial();
        end_of_test();
    end
endmodule : ttc_core_bench
